/* pqa_pkg.sv */
// How it works
// - Multiply low dwords per lane, full product
// - Wide form is two independent halves
// - Qword add/subtract lane by lane
// - Add/subtract wraps, keeps low 64 bits
// - Byte shifts move whole register, zero fill
// - Byte count above 15 clears result
// - Aligned split-safe load returns 16 bytes
// - Unaligned load fetches 32 bytes, extracts sixteen
// - Aligned load request count is implementation's
// - Wide load over narrow stores stalls
// - Misaligned narrow load after wide store stalls
package pqa_pkg;

   localparam int unsigned        DWORD_W   = 32;
   localparam int unsigned        LANE_W    = 64;
   localparam int unsigned        REG_W     = 128;
   localparam int unsigned        NUM_LANES = 2;
   localparam int unsigned        IMM_W     = 8;
   localparam int unsigned        ADDR_W    = 32;
   localparam int unsigned        OFS_W     = 4;
   localparam int unsigned        SIZE_W    = 3;
   localparam int unsigned        SB_DEPTH  = 4;
   localparam int unsigned        SB_IDX_W  = 2;
   localparam int unsigned        SB_CNT_W  = 3;

   localparam logic [IMM_W-1:0]    SHIFT_MAX  = 8'h0f;
   localparam logic [SIZE_W-1:0]   SIZE_16B   = 3'h4;
   localparam logic [ADDR_W-1:0]   BLK_STEP   = 32'h00000010;
   localparam logic [OFS_W-1:0]    OFS_ZERO   = 4'h0;
   localparam logic [5:0]          BLK_BYTES  = 6'h10;
   localparam logic [SB_CNT_W-1:0] SB_FULL    = 3'h4;
   localparam logic [1:0]          REQ_ONE    = 2'h1;
   localparam logic [1:0]          REQ_TWO    = 2'h2;

   typedef enum logic [2:0] {
      OP_MUL = 3'h0,
      OP_ADD = 3'h1,
      OP_SUB = 3'h2,
      OP_SHL = 3'h3,
      OP_SHR = 3'h4
   } pqa_op_type;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_STALL = 4'b0010,
      ST_REQ   = 4'b0100,
      ST_WAIT  = 4'b1000
   } pqa_ld_state_type;

endpackage : pqa_pkg

/* pqa_lane64.sv */
`timescale 1ns/1ps
module pqa_lane64 (
   // Operation
   input  pqa_pkg::pqa_op_type           op_code,
   // Lane operands and result
   input  wire logic [pqa_pkg::LANE_W-1:0] src_a,
   input  wire logic [pqa_pkg::LANE_W-1:0] src_b,
   output logic      [pqa_pkg::LANE_W-1:0] lane_res
);
   import pqa_pkg::*;

   // Same adder serves signed and unsigned operands
   always_comb begin
      case (op_code)
         OP_MUL:  lane_res = LANE_W'(src_a[DWORD_W-1:0]) * LANE_W'(src_b[DWORD_W-1:0]);
         OP_ADD:  lane_res = src_a + src_b;
         OP_SUB:  lane_res = src_a - src_b;
         default: lane_res = '0;
      endcase
   end

endmodule : pqa_lane64

/* pqa_core.sv */
`timescale 1ns/1ps
module pqa_core (
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         sys_rst,
   // Operation issue
   input  wire logic                         op_valid,
   input  pqa_pkg::pqa_op_type               op_code,
   input  wire logic                         op_wide,
   input  wire logic [pqa_pkg::REG_W-1:0]    src_a,
   input  wire logic [pqa_pkg::REG_W-1:0]    src_b,
   input  wire logic [pqa_pkg::IMM_W-1:0]    op_imm,
   // Operation result
   output logic                              res_valid,
   output logic      [pqa_pkg::REG_W-1:0]    res_data,
   // Load issue
   input  wire logic                         ld_valid,
   output logic                              ld_ready,
   input  wire logic [pqa_pkg::ADDR_W-1:0]   ld_addr,
   input  wire logic [pqa_pkg::SIZE_W-1:0]   ld_size,
   input  wire logic                         ld_split,
   // Load answer
   output logic                              ld_rsp_valid,
   output logic      [pqa_pkg::REG_W-1:0]    ld_rsp_data,
   output logic                              ld_stall,
   // Pending store tracking
   input  wire logic                         st_push,
   output logic                              st_ready,
   input  wire logic [pqa_pkg::ADDR_W-1:0]   st_addr,
   input  wire logic [pqa_pkg::SIZE_W-1:0]   st_size,
   input  wire logic                         st_retire,
   // Memory side
   output logic                              mem_req_valid,
   input  wire logic                         mem_req_ready,
   output logic      [pqa_pkg::ADDR_W-1:0]   mem_req_addr,
   input  wire logic                         mem_rsp_valid,
   input  wire logic [pqa_pkg::REG_W-1:0]    mem_rsp_data
);
   import pqa_pkg::*;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   function automatic logic [REG_W-1:0] byte_shift(input logic [REG_W-1:0] v,
                                                   input logic [IMM_W-1:0] imm,
                                                   input logic             left);
      logic [REG_W-1:0] r;
      r = '0;
      if (imm <= SHIFT_MAX) begin
         r = left ? (v << {imm[OFS_W-1:0], 3'b000}) : (v >> {imm[OFS_W-1:0], 3'b000});
      end
      return r;
   endfunction : byte_shift
   function automatic logic overlaps(input logic [ADDR_W-1:0] a, input logic [SIZE_W-1:0] sa,
                                     input logic [ADDR_W-1:0] b, input logic [SIZE_W-1:0] sb);
      logic [ADDR_W:0] a_end;
      logic [ADDR_W:0] b_end;
      a_end = {1'b0, a} + ((ADDR_W+1)'(1) << sa);
      b_end = {1'b0, b} + ((ADDR_W+1)'(1) << sb);
      return ({1'b0, a} < b_end) && ({1'b0, b} < a_end);
   endfunction : overlaps
   function automatic logic [REG_W-1:0] size_mask(input logic [SIZE_W-1:0] s);
      logic [REG_W-1:0] m;
      m = '0;
      for (int i = 0; i < REG_W / 8; i++) begin
         if (i < (32'd1 << s)) m[i*8 +: 8] = 8'hff;
      end
      return m;
   endfunction : size_mask
   // Execution lanes
   logic [REG_W-1:0] lane_res;
   logic [REG_W-1:0] exe_d;
   logic             res_valid_q;
   logic [REG_W-1:0] res_data_q;
   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g++) begin : g_lane
         pqa_lane64 u_lane (
            .op_code  (op_code),
            .src_a    (src_a[g*LANE_W +: LANE_W]),
            .src_b    (src_b[g*LANE_W +: LANE_W]),
            .lane_res (lane_res[g*LANE_W +: LANE_W])
         );
      end
   endgenerate
   // Narrow multiply, add and subtract leave the upper half at zero; byte shifts ignore op_wide
   always_comb begin
      case (op_code)
         OP_MUL, OP_ADD, OP_SUB: begin
            exe_d = op_wide ? lane_res : {{LANE_W{1'b0}}, lane_res[LANE_W-1:0]};
         end
         OP_SHL:  exe_d = byte_shift(src_a, op_imm, 1'b1);
         OP_SHR:  exe_d = byte_shift(src_a, op_imm, 1'b0);
         default: exe_d = '0;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         res_valid_q <= 1'b0;
         res_data_q  <= '0;
      end else begin
         res_valid_q <= op_valid;
         if (op_valid) begin
            res_data_q <= exe_d;
         end
      end
   end

   AST_MUL_FULL: assert property (
      op_valid && op_code == OP_MUL |=>
         res_data_q[LANE_W-1:0] ==
         LANE_W'($past(src_a[DWORD_W-1:0])) * LANE_W'($past(src_b[DWORD_W-1:0])))
      else $error("Low lane product wrong");
   AST_HALVES_APART: assert property (
      op_valid && op_wide && op_code == OP_ADD |=>
         res_data_q[REG_W-1:LANE_W] == $past(src_a[REG_W-1:LANE_W]) + $past(src_b[REG_W-1:LANE_W]))
      else $error("High lane not independent");
   AST_SUB_WRAP: assert property (
      op_valid && op_code == OP_SUB |=>
         res_data_q[LANE_W-1:0] == LANE_W'($past(src_a[LANE_W-1:0]) - $past(src_b[LANE_W-1:0])))
      else $error("Subtract did not wrap");
   AST_ADD_LANE: assert property (
      op_valid && op_code == OP_ADD |=>
         res_valid_q && res_data_q[LANE_W-1:0] ==
         LANE_W'($past(src_a[LANE_W-1:0]) + $past(src_b[LANE_W-1:0])))
      else $error("Add lane result wrong");
   AST_SHL_BYTES: assert property (
      op_valid && op_code == OP_SHL && op_imm <= SHIFT_MAX |=>
         res_data_q == ($past(src_a) << {$past(op_imm[OFS_W-1:0]), 3'b000}))
      else $error("Byte shift left wrong");
   AST_SHIFT_CLEAR: assert property (
      op_valid && (op_code == OP_SHL || op_code == OP_SHR) && op_imm > SHIFT_MAX |=>
         res_data_q == '0)
      else $error("Large shift count not cleared");

   // Pending stores, fixed slots so a load's older-store mask stays valid
   logic [ADDR_W-1:0]   sb_addr_q [SB_DEPTH];
   logic [SIZE_W-1:0]   sb_size_q [SB_DEPTH];
   logic [SB_DEPTH-1:0] sb_vld_q;
   logic [SB_IDX_W-1:0] sb_wr_q;
   logic [SB_IDX_W-1:0] sb_rd_q;
   logic [SB_CNT_W-1:0] sb_cnt_q;
   logic [SB_CNT_W-1:0] sb_cnt_d;
   logic                st_ready_q;
   logic                sb_push;
   logic                sb_pop;
   assign sb_push = st_push && st_ready_q;
   assign sb_pop  = st_retire && sb_vld_q[sb_rd_q];
   always_comb begin
      sb_cnt_d = sb_cnt_q;
      if (sb_push && !sb_pop) sb_cnt_d = sb_cnt_q + 3'h1;
      else if (sb_pop && !sb_push) sb_cnt_d = sb_cnt_q - 3'h1;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sb_wr_q    <= '0;
         sb_rd_q    <= '0;
         sb_cnt_q   <= '0;
         st_ready_q <= 1'b0;
      end else begin
         sb_cnt_q   <= sb_cnt_d;
         st_ready_q <= sb_cnt_d != SB_FULL;
         if (sb_push) sb_wr_q <= sb_wr_q + 2'h1;
         if (sb_pop) sb_rd_q <= sb_rd_q + 2'h1;
      end
   end

   // Load path state
   pqa_ld_state_type    state_q;
   pqa_ld_state_type    state_d;
   logic [ADDR_W-1:0]   la_addr_q;
   logic [SIZE_W-1:0]   la_size_q;
   logic                la_two_q;
   logic                la_beat_q;
   logic [REG_W-1:0]    blk_lo_q;
   logic [SB_DEPTH-1:0] older_q;
   logic [SB_DEPTH-1:0] ovl_vec;
   logic                hazard;
   logic                ld_take;
   logic [SIZE_W-1:0]   take_size;
   logic [5:0]          take_end;
   logic [2*REG_W-1:0]  blk_all;
   logic [2*REG_W-1:0]  blk_shift;
   logic                ld_ready_q;
   logic                ld_rsp_valid_q;
   logic [REG_W-1:0]    ld_rsp_data_q;
   logic                ld_stall_q;
   logic                mem_req_valid_q;
   logic [ADDR_W-1:0]   mem_req_addr_q;
   logic [1:0]          req_cnt_q;
   generate
      for (g = 0; g < SB_DEPTH; g++) begin : g_sb
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               sb_vld_q[g]  <= 1'b0;
               sb_addr_q[g] <= '0;
               sb_size_q[g] <= '0;
               older_q[g]   <= 1'b0;
            end else begin
               if (sb_push && sb_wr_q == SB_IDX_W'(g)) begin
                  sb_vld_q[g]  <= 1'b1;
                  sb_addr_q[g] <= st_addr;
                  sb_size_q[g] <= st_size;
               end else if (sb_pop && sb_rd_q == SB_IDX_W'(g)) begin
                  sb_vld_q[g] <= 1'b0;
               end
               // A store freed in the take cycle must not hold it; its slot may refill
               if (ld_take) begin
                  older_q[g] <= sb_vld_q[g] && !(sb_pop && sb_rd_q == SB_IDX_W'(g));
               end else if (sb_pop && sb_rd_q == SB_IDX_W'(g)) begin
                  older_q[g] <= 1'b0;
               end
            end
         end
         // No forwarding path: any overlap waits for the store to reach memory
         assign ovl_vec[g] = older_q[g] && sb_vld_q[g] &&
                             overlaps(la_addr_q, la_size_q, sb_addr_q[g], sb_size_q[g]);
      end
   endgenerate
   assign hazard    = |ovl_vec;
   assign ld_take   = ld_valid && ld_ready_q;
   assign take_size = ld_split ? SIZE_16B : ld_size;
   assign take_end  = {2'b00, ld_addr[OFS_W-1:0]} + (6'h1 << take_size);
   assign blk_all   = la_two_q ? {mem_rsp_data, blk_lo_q} : {{REG_W{1'b0}}, mem_rsp_data};
   assign blk_shift = blk_all >> {la_addr_q[OFS_W-1:0], 3'b000};
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:  if (ld_take) state_d = ST_STALL;
         ST_STALL: if (!hazard) state_d = ST_REQ;
         ST_REQ:   if (mem_req_ready) state_d = ST_WAIT;
         ST_WAIT: begin
            if (mem_rsp_valid) begin
               state_d = (la_two_q && !la_beat_q) ? ST_REQ : ST_IDLE;
            end
         end
         default:  state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q    <= ST_IDLE;
         ld_ready_q <= 1'b0;
         ld_stall_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         ld_ready_q <= state_d == ST_IDLE;
         ld_stall_q <= state_q == ST_STALL && hazard;
      end
   end

   // Capture of the request
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         la_addr_q <= '0;
         la_size_q <= '0;
         la_two_q  <= 1'b0;
      end else if (ld_take) begin
         la_addr_q <= ld_addr;
         la_size_q <= take_size;
         la_two_q  <= take_end > BLK_BYTES;
      end
   end
   // Memory requests, always on a 16-byte boundary
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mem_req_valid_q <= 1'b0;
         mem_req_addr_q  <= '0;
         la_beat_q       <= 1'b0;
         req_cnt_q       <= '0;
      end else begin
         if (ld_take) begin
            la_beat_q <= 1'b0;
            req_cnt_q <= '0;
         end
         if (state_q == ST_STALL && !hazard) begin
            mem_req_valid_q <= 1'b1;
            mem_req_addr_q  <= {la_addr_q[ADDR_W-1:OFS_W], OFS_ZERO};
         end else if (state_q == ST_REQ && mem_req_ready) begin
            mem_req_valid_q <= 1'b0;
            req_cnt_q       <= req_cnt_q + 2'h1;
         end else if (state_q == ST_WAIT && mem_rsp_valid && la_two_q && !la_beat_q) begin
            mem_req_valid_q <= 1'b1;
            mem_req_addr_q  <= mem_req_addr_q + BLK_STEP;
            la_beat_q       <= 1'b1;
         end
      end
   end
   // Answer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         blk_lo_q       <= '0;
         ld_rsp_valid_q <= 1'b0;
         ld_rsp_data_q  <= '0;
      end else begin
         ld_rsp_valid_q <= 1'b0;
         if (state_q == ST_WAIT && mem_rsp_valid) begin
            if (la_two_q && !la_beat_q) begin
               blk_lo_q <= mem_rsp_data;
            end else begin
               ld_rsp_valid_q <= 1'b1;
               ld_rsp_data_q  <= blk_shift[REG_W-1:0] & size_mask(la_size_q);
            end
         end
      end
   end

   AST_ALIGNED_ONE_REQ: assert property (
      ld_rsp_valid_q && !la_two_q |-> req_cnt_q == REQ_ONE)
      else $error("Aligned load used other than one request");
   AST_UNALIGNED_TWO_REQ: assert property (
      ld_rsp_valid_q && la_two_q |-> req_cnt_q == REQ_TWO)
      else $error("Unaligned load did not fetch two blocks");
   AST_REQ_ON_BOUNDARY: assert property (
      mem_req_valid_q |-> mem_req_addr_q[OFS_W-1:0] == OFS_ZERO && state_q == ST_REQ)
      else $error("Memory request not block aligned");
   AST_HOLD_ON_OVERLAP: assert property (
      state_q == ST_STALL && hazard |=> !mem_req_valid_q && state_q == ST_STALL)
      else $error("Load went to memory over pending store");
   AST_STALL_SHOWN: assert property (
      state_q == ST_STALL && hazard |=> ld_stall_q ##1 (ld_stall_q || !hazard))
      else $error("Stall not reported");
   COV_SPLIT_LOAD:   cover property (ld_rsp_valid_q && la_two_q);
   COV_STALLED_LOAD: cover property (ld_stall_q ##[1:20] ld_rsp_valid_q);
   COV_WIDE_MUL:     cover property (op_valid && op_wide && op_code == OP_MUL);
   assign res_valid     = res_valid_q;
   assign res_data      = res_data_q;
   assign ld_ready      = ld_ready_q;
   assign ld_rsp_valid  = ld_rsp_valid_q;
   assign ld_rsp_data   = ld_rsp_data_q;
   assign ld_stall      = ld_stall_q;
   assign st_ready      = st_ready_q;
   assign mem_req_valid = mem_req_valid_q;
   assign mem_req_addr  = mem_req_addr_q;

endmodule : pqa_core

/* pqa_mem_model.sv */
`timescale 1ns/1ps
module pqa_mem_model (
   // Clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   // Pacing control
   input  wire logic                       slow,
   // Request side
   input  wire logic                       mem_req_valid,
   output logic                            mem_req_ready,
   input  wire logic [pqa_pkg::ADDR_W-1:0] mem_req_addr,
   // Answer side
   output logic                            mem_rsp_valid,
   output logic      [pqa_pkg::REG_W-1:0]  mem_rsp_data,
   output logic      [7:0]                 req_count
);
   import pqa_pkg::*;

   logic [1:0] wait_q;
   logic       take;

   // Contents are a fixed function of the byte address, so the bench can predict them
   function automatic logic [REG_W-1:0] mem_block(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] b;
      for (int i = 0; i < 16; i++) begin
         b = a + 32'(i);
         mem_block[i*8 +: 8] = b[7:0] ^ b[15:8] ^ 8'h3c;
      end
   endfunction : mem_block

   // Slow mode holds ready back two cycles to keep the load in ST_REQ
   assign mem_req_ready = mem_req_valid && (!slow || wait_q == 2'h2);
   assign take          = mem_req_valid && mem_req_ready;

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !mem_req_valid || mem_req_ready)
         wait_q <= 2'h0;
      else
         wait_q <= wait_q + 2'h1;
   end

   // Data lines toggle when no answer stands, so stale data is never mistaken for valid
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mem_rsp_valid <= 1'b0;
         mem_rsp_data  <= 128'h0;
         req_count     <= 8'h0;
      end else begin
         mem_rsp_valid <= take;
         mem_rsp_data  <= take ? mem_block(mem_req_addr) : ~mem_rsp_data;
         req_count     <= req_count + {7'h0, take};
      end
   end
endmodule : pqa_mem_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import pqa_pkg::*;

   logic              clk_sys, sys_rst, op_valid, op_wide, ld_valid, ld_split;
   logic              st_push, st_retire, slow, res_valid, ld_ready, ld_rsp_valid;
   logic              ld_stall, st_ready, mem_req_valid, mem_req_ready, mem_rsp_valid;
   logic              exp_v, tsp;
   pqa_op_type        op_code;
   logic [REG_W-1:0]  src_a, src_b, res_data, ld_rsp_data, mem_rsp_data, exp_d;
   logic [IMM_W-1:0]  op_imm;
   logic [ADDR_W-1:0] ld_addr, st_addr, mem_req_addr, ta;
   logic [SIZE_W-1:0] ld_size, st_size, ts;
   logic [7:0]        req_count, n0;
   logic [7:0]        imms [6] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'h11, 8'hff};
   int                n_mismatch = 0, tests_run = 0, cyc = 0, seed;

   pqa_core pqa_core_i (.clk_sys, .sys_rst, .op_valid, .op_code, .op_wide, .src_a, .src_b,
      .op_imm, .res_valid, .res_data, .ld_valid, .ld_ready, .ld_addr, .ld_size, .ld_split,
      .ld_rsp_valid, .ld_rsp_data, .ld_stall, .st_push, .st_ready, .st_addr, .st_size,
      .st_retire, .mem_req_valid, .mem_req_ready, .mem_req_addr, .mem_rsp_valid,
      .mem_rsp_data);
   pqa_mem_model pqa_mem_model_i (.clk_sys, .sys_rst, .slow, .mem_req_valid, .mem_req_ready,
      .mem_req_addr, .mem_rsp_valid, .mem_rsp_data, .req_count);

   function automatic logic [REG_W-1:0] op_model(pqa_op_type c, logic w, logic [REG_W-1:0] a,
                                                 logic [REG_W-1:0] b, logic [7:0] n);
      logic [REG_W-1:0] r;
      r = 128'h0;
      for (int l = 0; l < 2; l++) begin
         case (c)
            OP_MUL: r[l*64 +: 64] = 64'(a[l*64 +: 32]) * 64'(b[l*64 +: 32]);
            OP_ADD: r[l*64 +: 64] = a[l*64 +: 64] + b[l*64 +: 64];
            OP_SUB: r[l*64 +: 64] = a[l*64 +: 64] - b[l*64 +: 64];
            default: ;
         endcase
      end
      if (!w)
         r[127:64] = 64'h0;
      if (c == OP_SHL && n <= 8'h0f)
         r = a << {n, 3'h0};
      if (c == OP_SHR && n <= 8'h0f)
         r = a >> {n, 3'h0};
      return r;
   endfunction : op_model

   function automatic logic [REG_W-1:0] ld_model(logic [ADDR_W-1:0] a, logic [2:0] s, logic sp);
      logic [REG_W-1:0]  r;
      logic [ADDR_W-1:0] b;
      r = 128'h0;
      for (int i = 0; i < 16; i++) begin
         b = a + 32'(i);
         if (sp || i < (1 << s))
            r[i*8 +: 8] = b[7:0] ^ b[15:8] ^ 8'h3c;
      end
      return r;
   endfunction : ld_model

   function automatic logic [REG_W-1:0] rnd();
      return {$random(seed), $random(seed), $random(seed), $random(seed)};
   endfunction : rnd

   task automatic check(logic ok, string msg);
      tests_run++;
      if (!ok) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic conclude();
      $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic op(pqa_op_type c, logic w, logic [REG_W-1:0] a, logic [REG_W-1:0] b,
                     logic [7:0] n);
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_code  <= c;
      op_wide  <= w;
      src_a    <= a;
      src_b    <= b;
      op_imm   <= n;
   endtask : op

   // Ready is sampled at the negedge, where it already equals its value at the next edge
   task automatic take(logic sel);
      logic rdy;
      do begin
         @(negedge clk_sys);
         rdy = sel ? st_ready : ld_ready;
         @(posedge clk_sys);
      end while (!rdy);
   endtask : take

   task automatic ld_start(logic [ADDR_W-1:0] a, logic [2:0] s, logic sp);
      @(posedge clk_sys);
      ld_valid <= 1'b1;
      ld_addr  <= a;
      ld_size  <= s;
      ld_split <= sp;
      take(1'b0);
      ld_valid <= 1'b0;
      n0 = req_count;
   endtask : ld_start

   task automatic ld_finish(logic [ADDR_W-1:0] a, logic [2:0] s, logic sp);
      int       k;
      logic [5:0] e;
      k = 0;
      e = {2'h0, a[3:0]} + (sp ? 6'h10 : 6'h1 << s);
      while (ld_rsp_valid !== 1'b1 && k < 300) begin
         @(negedge clk_sys);
         k++;
      end
      check(k < 300 && ld_rsp_data === ld_model(a, s, sp), "load data");
      check(req_count - n0 === (e > 6'h10 ? 8'h2 : 8'h1), "request count");
   endtask : ld_finish

   task automatic st(logic [ADDR_W-1:0] a, logic [2:0] s);
      @(posedge clk_sys);
      st_push <= 1'b1;
      st_addr <= a;
      st_size <= s;
      take(1'b1);
      st_push <= 1'b0;
   endtask : st

   task automatic retire();
      @(posedge clk_sys);
      st_retire <= 1'b1;
      @(posedge clk_sys);
      st_retire <= 1'b0;
   endtask : retire

   task automatic hold_stall(int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(negedge clk_sys);
         if (ld_stall !== 1'b1 || ld_rsp_valid !== 1'b0)
            ok = 1'b0;
      end
      check(ok, "load not held back");
   endtask : hold_stall

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Every issued operation must answer exactly one cycle later; nothing else may answer
   always @(posedge clk_sys) begin
      exp_v <= op_valid && !sys_rst;
      exp_d <= op_model(op_code, op_wide, src_a, src_b, op_imm);
   end
   always @(negedge clk_sys)
      if (!sys_rst && (exp_v === 1'b1 || res_valid !== 1'b0))
         check(res_valid === exp_v && res_data === exp_d, "op result");

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      seed = 32'h50b4;
      {op_valid, op_wide, ld_valid, ld_split, st_push, st_retire, slow} = 7'h0;
      op_code = OP_MUL;
      {src_a, src_b} = 256'h0;
      {ld_addr, st_addr} = 64'h0;
      {op_imm, ld_size, st_size} = 14'h0;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      // Carry must not cross lanes; the upper dword of each lane must not reach the product
      op(OP_ADD, 1'b1, {2{64'hffffffffffffffff}}, {2{64'h1}}, 8'h0);
      op(OP_SUB, 1'b1, 128'h0, {2{64'h1}}, 8'h0);
      op(OP_MUL, 1'b1, {2{64'h12345678ffffffff}}, {2{64'h9abcdef0ffffffff}}, 8'h0);
      op(OP_MUL, 1'b0, rnd(), rnd(), 8'h0);
      for (int i = 0; i < 6; i++) begin
         op(OP_SHL, 1'b0, rnd(), rnd(), imms[i]);
         op(OP_SHR, 1'b1, rnd(), rnd(), imms[i]);
      end
      repeat (200)
         op(pqa_op_type'(3'($random(seed))), 1'($random(seed)), rnd(), rnd(),
            8'($random(seed)) & 8'h1f);
      @(posedge clk_sys);
      op_valid <= 1'b0;
      $display("test ops done");
      for (int i = 0; i < 48; i++) begin
         ta = (i < 4) ? 32'h100 + 32'(i * 7) : 32'($random(seed)) & 32'h0000ffff;
         ts = 3'($random(seed)) % 3'h5;
         tsp = (i < 4) || 1'($random(seed));
         slow <= 1'($random(seed));
         ld_start(ta, ts, tsp);
         ld_finish(ta, ts, tsp);
      end
      $display("test loads done");
      // Two narrow stores under one wide load, with the tracker filled to refusal
      st(32'h200, 3'h2);
      st(32'h204, 3'h2);
      st(32'h400, 3'h4);
      st(32'h300, 3'h0);
      @(negedge clk_sys);
      check(st_ready === 1'b0, "tracker not full");
      ld_start(32'h200, 3'h3, 1'b0);
      repeat (3) @(negedge clk_sys);
      hold_stall(10);
      retire();
      hold_stall(5);
      retire();
      ld_finish(32'h200, 3'h3, 1'b0);
      retire();
      retire();
      $display("test wide over narrow done");
      st(32'h500, 3'h3);
      ld_start(32'h502, 3'h1, 1'b0);
      repeat (3) @(negedge clk_sys);
      hold_stall(8);
      retire();
      ld_finish(32'h502, 3'h1, 1'b0);
      $display("test narrow after wide done");
      conclude();
   end
endmodule : tb_top
